// [rtl/ocd_regs.svh]
/*
  Constants for the opcode decode tail: opcodes, cycle totals, flag bit
  positions and reset values.
  Assumes it is included by bare name from the rtl/ folder.
*/
`ifndef OCD_REGS_SVH
`define OCD_REGS_SVH

// ----------------------------------------------------------------
// Opcodes handled in full
// ----------------------------------------------------------------
`define OCD_OP_ZTEST_DIR   8'h3d
`define OCD_OP_ZTEST_ACC   8'h4d
`define OCD_OP_ZTEST_IDX   8'h5d
`define OCD_OP_ZTEST_BYTE  8'h6d
`define OCD_OP_ZTEST_NOOFS 8'h7d
`define OCD_OP_COPY_XA     8'h9f
`define OCD_OP_PAUSE       8'h8f
// Literal loads; with copy 9F, the only writers of A and X in this block
`define OCD_OP_LOAD_A      8'ha6
`define OCD_OP_LOAD_X      8'hae

// ----------------------------------------------------------------
// Cycle totals, counted from the cycle the opcode is on the bus
// ----------------------------------------------------------------
`define OCD_CYC_ZTEST_DIR   4'h4
`define OCD_CYC_ZTEST_REG   4'h3
`define OCD_CYC_ZTEST_BYTE  4'h5
`define OCD_CYC_ZTEST_NOOFS 4'h4
`define OCD_CYC_COPY_XA  4'h2
`define OCD_CYC_PAUSE    4'h2

// ----------------------------------------------------------------
// Condition flag bit positions and reset values
// ----------------------------------------------------------------
`define OCD_FLG_H        4
`define OCD_FLG_I        3
`define OCD_FLG_N        2
`define OCD_FLG_Z        1
`define OCD_FLG_C        0
`define OCD_FLAGS_RST    8'he8
`define OCD_PC_RST       16'h0000

`endif

// [rtl/ocd_pkg.sv]
/*
  Types for the opcode decode tail: sequencer states and operand modes.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ocd_pkg;

  typedef enum logic [4:0] {
    st_decode = 5'h01,
    st_opnd   = 5'h02,
    st_mem    = 5'h04,
    st_pad    = 5'h08,
    st_sleep  = 5'h10
  } ocd_state_type;

  typedef enum logic [3:0] {
    implied_operand_mode = 4'h0,
    literal_operand_mode = 4'h1,
    direct_mode          = 4'h2,
    absolute_16bit_addressing = 4'h3,
    indexed_word_offset  = 4'h4,
    indexed_byte_offset  = 4'h5,
    indexed_no_offset    = 4'h6,
    bit_branch_mode      = 4'h7,
    relative_mode        = 4'h8
  } ocd_mode_type;

endpackage

// [rtl/ocd_ea_if.sv]
/*
  Interface between the core tail and its address former.
  Assumes both ends sit on the same clock; all signals are combinational.
*/
`timescale 1ns/1ns
interface ocd_ea_if;
  ocd_pkg::ocd_mode_type mode;
  logic [7:0]            x;
  logic [7:0]            hi;
  logic [7:0]            lo;
  logic [15:0]           pc_past;
  logic [15:0]           ea;
  logic [15:0]           target;

  modport calc (input mode, x, hi, lo, pc_past, output ea, target);
  modport user (output mode, x, hi, lo, pc_past, input ea, target);
endinterface

// [rtl/ocd_ea_calc.sv]
/*
  Address former: operand address and relative branch target from the
  operand bytes, the index register and the address past the instruction.
  Assumes lo is the last operand byte and hi the one before it.
*/
`timescale 1ns/1ns
module ocd_ea_calc (
  ocd_ea_if.calc eif
);

  // ----------------------------------------------------------------
  // Address per mode
  // ----------------------------------------------------------------
  always_comb begin
    eif.ea     = 16'h0000;
    eif.target = eif.pc_past + {{8{eif.lo[7]}}, eif.lo};
    case (eif.mode)
      ocd_pkg::bit_branch_mode: begin
        eif.ea = {8'h00, eif.hi};
      end
      ocd_pkg::direct_mode: begin
        eif.ea = {8'h00, eif.lo};
      end
      ocd_pkg::absolute_16bit_addressing: begin
        eif.ea = {eif.hi, eif.lo};
      end
      ocd_pkg::indexed_word_offset: begin
        eif.ea = {eif.hi, eif.lo} + {8'h00, eif.x};
      end
      ocd_pkg::indexed_byte_offset: begin
        eif.ea = {8'h00, eif.x} + {8'h00, eif.lo};
      end
      ocd_pkg::indexed_no_offset: begin
        eif.ea = {8'h00, eif.x};
      end
      default: begin
        eif.ea = 16'h0000;
      end
    endcase
  end

endmodule

// [rtl/ocd_core_tail.sv]
/*
  Core tail: fetches opcode and operand bytes, forms operand addresses,
  runs test-against-zero, copy-index-to-accumulator and the pause opcode.
  Assumes program memory answers combinationally: mem_rdata holds the byte
  at mem_addr_r in the same cycle. irq_pin is asynchronous.
*/
`timescale 1ns/1ns
`include "ocd_regs.svh"

// Summary of operation
// - Test-against-zero (3D, 4D, 5D, 6D, 7D) sets only N and Z from its operand.
// - Opcode 9F copies X into A in 2 cycles and leaves every flag alone.
// - Opcode 8F clears the interrupt mask in 2 cycles, then halts until an interrupt.
// - Byte-offset indexing fetches one byte and adds it to X.
// - Word-offset indexing fetches two bytes, high first, and adds them to X.
// - Absolute addressing fetches two bytes, high first, as the operand address.
// - Bit-test-and-branch carries a direct address byte then a branch offset byte.
// - The opcode's upper nibble selects the addressing group.
module ocd_core_tail (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        irq_pin,
  input  wire logic [7:0]  mem_rdata,
  output logic      [15:0] mem_addr_r,
  output logic      [15:0] pc_r,
  output logic      [7:0]  acc_r,
  output logic      [7:0]  index_r,
  output logic      [7:0]  cond_flags_r,
  output logic             halt_r,
  output logic             instr_done_r,
  output logic      [15:0] ea_r,
  output logic      [15:0] branch_target_r
);

  ocd_pkg::ocd_state_type state_r;
  ocd_pkg::ocd_mode_type  mode_r;
  ocd_pkg::ocd_mode_type  dec_mode;
  logic [7:0]             op_r;
  logic [7:0]             hi_r;
  logic [1:0]             left_r;
  logic                   mem_r;
  logic [3:0]             cnt_r;
  logic [3:0]             total_r;
  logic [1:0]             dec_bytes;
  logic                   dec_mem;
  logic [3:0]             dec_total;
  logic                   irq_meta_r;
  logic                   irq_sync_r;
  logic                   finish;
  logic                   is_dec;

  ocd_ea_if eif ();

  ocd_ea_calc u_ea (
    .eif (eif)
  );

  assign is_dec      = (state_r == ocd_pkg::st_decode);
  assign finish      = (state_r == ocd_pkg::st_pad) && (cnt_r == total_r);
  assign eif.mode    = is_dec ? dec_mode : mode_r;
  assign eif.x       = index_r;
  assign eif.hi      = hi_r;
  assign eif.lo      = mem_rdata;
  assign eif.pc_past = pc_r + 16'h0001;

  // ----------------------------------------------------------------
  // Interrupt pin synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_meta_r <= 1'b0;
      irq_sync_r <= 1'b0;
    end else begin
      irq_meta_r <= irq_pin;
      irq_sync_r <= irq_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Opcode decode
  // ----------------------------------------------------------------
  always_comb begin
    dec_mode  = ocd_pkg::implied_operand_mode;
    dec_bytes = 2'h0;
    dec_mem   = 1'b0;
    case (mem_rdata[7:4])
      4'h0: begin
        dec_mode  = ocd_pkg::bit_branch_mode;
        dec_bytes = 2'h2;
      end
      4'h1: begin
        dec_mode  = ocd_pkg::direct_mode;
        dec_bytes = 2'h1;
      end
      4'h2: begin
        dec_mode  = ocd_pkg::relative_mode;
        dec_bytes = 2'h1;
      end
      4'h3, 4'hb: begin
        dec_mode  = ocd_pkg::direct_mode;
        dec_bytes = 2'h1;
        dec_mem   = 1'b1;
      end
      4'h6, 4'he: begin
        dec_mode  = ocd_pkg::indexed_byte_offset;
        dec_bytes = 2'h1;
        dec_mem   = 1'b1;
      end
      4'h7, 4'hf: begin
        dec_mode  = ocd_pkg::indexed_no_offset;
        dec_mem   = 1'b1;
      end
      4'ha: begin
        dec_mode  = ocd_pkg::literal_operand_mode;
        dec_bytes = 2'h1;
      end
      4'hc: begin
        dec_mode  = ocd_pkg::absolute_16bit_addressing;
        dec_bytes = 2'h2;
        dec_mem   = 1'b1;
      end
      4'hd: begin
        dec_mode  = ocd_pkg::indexed_word_offset;
        dec_bytes = 2'h2;
        dec_mem   = 1'b1;
      end
      default: begin
        dec_mode  = ocd_pkg::implied_operand_mode;
      end
    endcase
    case (mem_rdata)
      `OCD_OP_ZTEST_DIR:   dec_total = `OCD_CYC_ZTEST_DIR;
      `OCD_OP_ZTEST_ACC:   dec_total = `OCD_CYC_ZTEST_REG;
      `OCD_OP_ZTEST_IDX:   dec_total = `OCD_CYC_ZTEST_REG;
      `OCD_OP_ZTEST_BYTE:  dec_total = `OCD_CYC_ZTEST_BYTE;
      `OCD_OP_ZTEST_NOOFS: dec_total = `OCD_CYC_ZTEST_NOOFS;
      `OCD_OP_COPY_XA:   dec_total = `OCD_CYC_COPY_XA;
      `OCD_OP_PAUSE:     dec_total = `OCD_CYC_PAUSE;
      // Other opcodes: fetch, one cycle per operand byte, one memory read if any, one closing cycle
      default:           dec_total = 4'h2 + {2'h0, dec_bytes} + {3'h0, dec_mem};
    endcase
  end

  // ----------------------------------------------------------------
  // Fetch sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r      <= ocd_pkg::st_decode;
      mode_r       <= ocd_pkg::implied_operand_mode;
      mem_addr_r   <= `OCD_PC_RST;
      pc_r         <= `OCD_PC_RST;
      op_r         <= 8'h00;
      hi_r         <= 8'h00;
      left_r       <= 2'h0;
      mem_r        <= 1'b0;
      cnt_r        <= 4'h1;
      total_r      <= 4'h2;
      halt_r       <= 1'b0;
      instr_done_r <= 1'b0;
    end else begin
      instr_done_r <= finish;
      case (state_r)
        ocd_pkg::st_decode: begin
          op_r    <= mem_rdata;
          mode_r  <= dec_mode;
          total_r <= dec_total;
          left_r  <= dec_bytes;
          mem_r   <= dec_mem;
          pc_r    <= pc_r + 16'h0001;
          cnt_r   <= 4'h2;
          if (dec_bytes != 2'h0) begin
            state_r    <= ocd_pkg::st_opnd;
            mem_addr_r <= pc_r + 16'h0001;
          end else if (dec_mem) begin
            state_r    <= ocd_pkg::st_mem;
            mem_addr_r <= eif.ea;
          end else begin
            state_r    <= ocd_pkg::st_pad;
          end
        end
        ocd_pkg::st_opnd: begin
          pc_r   <= pc_r + 16'h0001;
          cnt_r  <= cnt_r + 4'h1;
          left_r <= left_r - 2'h1;
          hi_r   <= mem_rdata;
          if (left_r == 2'h2) begin
            mem_addr_r <= pc_r + 16'h0001;
          end else if (mem_r) begin
            state_r    <= ocd_pkg::st_mem;
            mem_addr_r <= eif.ea;
          end else begin
            state_r    <= ocd_pkg::st_pad;
          end
        end
        ocd_pkg::st_mem: begin
          cnt_r   <= cnt_r + 4'h1;
          state_r <= ocd_pkg::st_pad;
        end
        ocd_pkg::st_pad: begin
          if (finish) begin
            // Next opcode address is loaded at the end of the closing cycle and goes out in the decode cycle
            cnt_r      <= 4'h1;
            mem_addr_r <= pc_r;
            if (op_r == `OCD_OP_PAUSE) begin
              state_r <= ocd_pkg::st_sleep;
              halt_r  <= 1'b1;
            end else begin
              state_r <= ocd_pkg::st_decode;
            end
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ocd_pkg::st_sleep: begin
          if (irq_sync_r) begin
            state_r <= ocd_pkg::st_decode;
            halt_r  <= 1'b0;
          end
        end
        default: begin
          state_r <= ocd_pkg::st_decode;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Address outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      ea_r            <= 16'h0000;
      branch_target_r <= 16'h0000;
    end else if (state_r == ocd_pkg::st_opnd && left_r == 2'h1) begin
      ea_r            <= eif.ea;
      branch_target_r <= eif.target;
    end else if (is_dec && dec_bytes == 2'h0 && dec_mem) begin
      ea_r <= eif.ea;
    end
  end

  // ----------------------------------------------------------------
  // Accumulator, index and flags
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      acc_r        <= 8'h00;
      index_r      <= 8'h00;
      cond_flags_r <= `OCD_FLAGS_RST;
    end else if (state_r == ocd_pkg::st_opnd && mode_r == ocd_pkg::literal_operand_mode) begin
      // Literal loads, flags kept, so X can hold more than zero
      if (op_r == `OCD_OP_LOAD_A) begin
        acc_r <= mem_rdata;
      end else if (op_r == `OCD_OP_LOAD_X) begin
        index_r <= mem_rdata;
      end
    end else if (state_r == ocd_pkg::st_mem) begin
      if (op_r == `OCD_OP_ZTEST_DIR || op_r == `OCD_OP_ZTEST_BYTE ||
          op_r == `OCD_OP_ZTEST_NOOFS) begin
        cond_flags_r[`OCD_FLG_N] <= mem_rdata[7];
        cond_flags_r[`OCD_FLG_Z] <= (mem_rdata == 8'h00);
      end
    end else if (finish) begin
      case (op_r)
        `OCD_OP_ZTEST_ACC: begin
          cond_flags_r[`OCD_FLG_N] <= acc_r[7];
          cond_flags_r[`OCD_FLG_Z] <= (acc_r == 8'h00);
        end
        `OCD_OP_ZTEST_IDX: begin
          cond_flags_r[`OCD_FLG_N] <= index_r[7];
          cond_flags_r[`OCD_FLG_Z] <= (index_r == 8'h00);
        end
        `OCD_OP_COPY_XA: acc_r <= index_r;
        `OCD_OP_PAUSE:   cond_flags_r[`OCD_FLG_I] <= 1'b0;
        default:         acc_r <= acc_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_dec(logic [7:0] op);
    is_dec && mem_rdata == op;
  endsequence

  property p_ztest_flags;
    state_r == ocd_pkg::st_mem && (op_r == `OCD_OP_ZTEST_DIR ||
      op_r == `OCD_OP_ZTEST_BYTE || op_r == `OCD_OP_ZTEST_NOOFS)
    |=> cond_flags_r[`OCD_FLG_N] == $past(mem_rdata[7])
        && cond_flags_r[`OCD_FLG_Z] == ($past(mem_rdata) == 8'h00)
        && cond_flags_r[`OCD_FLG_C] == $past(cond_flags_r[`OCD_FLG_C])
        && cond_flags_r[`OCD_FLG_H] == $past(cond_flags_r[`OCD_FLG_H]);
  endproperty
  a_ztest_flags: assert property (p_ztest_flags) else $error("test flags wrong");

  property p_ztest_dir_len;
    s_dec(`OCD_OP_ZTEST_DIR) |-> !finish [*3] ##1 finish;
  endproperty
  a_ztest_dir_len: assert property (p_ztest_dir_len) else $error("direct test length");

  property p_ztest_reg_len;
    s_dec(`OCD_OP_ZTEST_ACC) or s_dec(`OCD_OP_ZTEST_IDX) |-> ##1 !finish ##1 finish;
  endproperty
  a_ztest_reg_len: assert property (p_ztest_reg_len) else $error("register test length");

  property p_ztest_byte_len;
    s_dec(`OCD_OP_ZTEST_BYTE) |-> !finish [*4] ##1 finish;
  endproperty
  a_ztest_byte_len: assert property (p_ztest_byte_len) else $error("byte offset test length");

  property p_copy;
    s_dec(`OCD_OP_COPY_XA) |-> ##1 finish ##1 (acc_r == index_r && $stable(cond_flags_r));
  endproperty
  a_copy: assert property (p_copy) else $error("copy index wrong");

  property p_pause;
    s_dec(`OCD_OP_PAUSE) |-> ##1 finish ##1 (halt_r && !cond_flags_r[`OCD_FLG_I]);
  endproperty
  a_pause: assert property (p_pause) else $error("pause did not halt");

  property p_byte_ofs;
    is_dec && mem_rdata[7:4] == 4'h6 |-> ##1 mem_addr_r == pc_r
      ##1 mem_addr_r == {8'h00, index_r} + {8'h00, $past(mem_rdata)};
  endproperty
  a_byte_ofs: assert property (p_byte_ofs) else $error("byte offset address");

  property p_word_ofs;
    is_dec && mem_rdata[7:4] == 4'hd
    |-> ##3 mem_addr_r == {$past(mem_rdata, 2), $past(mem_rdata)} + {8'h00, index_r};
  endproperty
  a_word_ofs: assert property (p_word_ofs) else $error("word offset address");

  property p_absolute;
    is_dec && mem_rdata[7:4] == 4'hc
    |-> ##3 mem_addr_r == {$past(mem_rdata, 2), $past(mem_rdata)};
  endproperty
  a_absolute: assert property (p_absolute) else $error("absolute address");

  property p_bit_branch;
    is_dec && mem_rdata[7:4] == 4'h0
    |-> ##3 ea_r == {8'h00, $past(mem_rdata, 2)}
        && branch_target_r == $past(pc_r) + 16'h0001
           + {{8{$past(mem_rdata[7])}}, $past(mem_rdata)};
  endproperty
  a_bit_branch: assert property (p_bit_branch) else $error("bit branch operands");

  property p_group;
    is_dec && (mem_rdata[7:4] == 4'h8 || mem_rdata[7:4] == 4'h9)
    |=> state_r == ocd_pkg::st_pad;
  endproperty
  a_group: assert property (p_group) else $error("control group fetched operand");

endmodule

// [testbench/ocd_prog_mem.sv]
/*
  Program memory model for the core tail: one byte per address, answered
  in the same cycle as the address is shown.
  Assumes the bench loads the bytes through put while reset is held.
*/
`timescale 1ns/1ns
module ocd_prog_mem (
  input  wire logic [15:0] mem_addr,
  output logic      [7:0]  mem_rdata
);
  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] mem_array [0:65535];

  // Zero latency is what the core expects; a slower memory breaks it
  assign mem_rdata = mem_array[mem_addr];

  // Unloaded space holds an implied opcode, so a runaway fetch stays harmless
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem_array[i] = 8'h9d;
    end
  end

  task automatic put(input logic [15:0] addr, input logic [7:0] data);
    mem_array[addr] = data;
  endtask
endmodule

// [testbench/ocd_core_tail_tb_top.sv]
/*
  Self-checking bench for the core tail: runs one program through the
  flag tests, operand fetches, opcode groups, branch targets and pause.
  Assumes the program memory model answers combinationally.
*/
`timescale 1ns/1ns
module ocd_core_tail_tb_top;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        mclk;
  logic        rst;
  logic        irq_pin;
  logic [7:0]  mem_rdata;
  logic [15:0] mem_addr_r;
  logic [15:0] pc_r;
  logic [7:0]  acc_r;
  logic [7:0]  index_r;
  logic [7:0]  cond_flags_r;
  logic        halt_r;
  logic        instr_done_r;
  logic [15:0] ea_r;
  logic [15:0] branch_target_r;
  int          fails;
  int          comparisons;
  logic [15:0] ip;
  logic [7:0]  fl;
  logic [7:0]  prog [0:46];

  ocd_prog_mem mem (.mem_addr(mem_addr_r), .mem_rdata(mem_rdata));

  ocd_core_tail dut (
    .mclk(mclk), .rst(rst), .irq_pin(irq_pin), .mem_rdata(mem_rdata),
    .mem_addr_r(mem_addr_r), .pc_r(pc_r), .acc_r(acc_r), .index_r(index_r),
    .cond_flags_r(cond_flags_r), .halt_r(halt_r), .instr_done_r(instr_done_r),
    .ea_r(ea_r), .branch_target_r(branch_target_r)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Counts edges from the previous done pulse; cyc zero skips the count
  task automatic step(input int len, input logic [3:0] cyc, input logic chk_ea,
                      input logic [15:0] ea);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (instr_done_r !== 1'b1 && n < 40);
    if (instr_done_r !== 1'b1) begin
      fails++;
      $display("CHECK FAILED instr_done_r expected 1 seen none");
      give_verdict();
    end else begin
      ip = ip + 16'(len);
      if (cyc != 4'h0) check("cycles", 16'(n), {12'h000, cyc});
      check("mem_addr_r", mem_addr_r, ip);
      check("cond_flags_r", {8'h00, cond_flags_r}, {8'h00, fl});
      if (chk_ea) check("ea_r", ea_r, ea);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_zero_flags;
    step(1, 4'h0, 1'b0, 16'h0000);
    fl = 8'hec;
    step(2, 4'h4, 1'b1, 16'h0040);
    fl = 8'hea;
    step(1, 4'h3, 1'b0, 16'h0000);
    fl = 8'he8;
    step(2, 4'h4, 1'b1, 16'h0041);
    fl = 8'hea;
    step(1, 4'h3, 1'b0, 16'h0000);
    step(2, 4'h5, 1'b1, 16'h0090);
    fl = 8'hec;
    step(1, 4'h4, 1'b1, 16'h0000);
    $display("test_zero_flags done");
  endtask

  task automatic test_copy;
    step(1, 4'h2, 1'b0, 16'h0000);
    check("acc_r", {8'h00, acc_r}, 16'h0000);
    $display("test_copy done");
  endtask

  task automatic test_operand_fetch;
    step(3, 4'h5, 1'b1, 16'h1234);
    step(3, 4'h5, 1'b1, 16'h0123);
    step(2, 4'h4, 1'b1, 16'h007f);
    $display("test_operand_fetch done");
  endtask

  task automatic test_group_map;
    step(2, 4'h3, 1'b0, 16'h0000);
    step(2, 4'h4, 1'b1, 16'h0044);
    step(1, 4'h3, 1'b1, 16'h0000);
    step(2, 4'h3, 1'b1, 16'h0045);
    step(1, 4'h2, 1'b0, 16'h0000);
    step(1, 4'h2, 1'b0, 16'h0000);
    $display("test_group_map done");
  endtask

  task automatic test_branch;
    step(3, 4'h4, 1'b1, 16'h0050);
    check("branch_target_r", branch_target_r, ip + 16'hfffe);
    step(2, 4'h3, 1'b0, 16'h0000);
    check("branch_target_r", branch_target_r, ip + 16'h0010);
    $display("test_branch done");
  endtask

  task automatic test_pause;
    int n;
    fl = fl & 8'hf7;
    step(1, 4'h2, 1'b0, 16'h0000);
    check("halt_r", {15'h0000, halt_r}, 16'h0001);
    repeat (6) @(posedge mclk);
    #1;
    check("halt_r held", {15'h0000, halt_r}, 16'h0001);
    check("mem_addr_r held", mem_addr_r, ip);
    @(posedge mclk);
    irq_pin <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (halt_r !== 1'b0 && n < 8);
    check("halt release", 16'(n), 16'h0003);
    // Request stays high while running; it must have no effect there
    step(1, 4'h0, 1'b0, 16'h0000);
    step(1, 4'h2, 1'b0, 16'h0000);
    check("halt_r running", {15'h0000, halt_r}, 16'h0000);
    irq_pin <= 1'b0;
    $display("test_pause done");
  endtask

  // A was loaded with 55 in the group map; X gets a nonzero value here
  task automatic test_loads;
    fl = 8'he0;
    step(1, 4'h3, 1'b0, 16'h0000);
    step(2, 4'h3, 1'b0, 16'h0000);
    check("index_r", {8'h00, index_r}, 16'h0083);
    fl = 8'he4;
    step(1, 4'h3, 1'b0, 16'h0000);
    step(1, 4'h2, 1'b0, 16'h0000);
    check("acc_r copied", {8'h00, acc_r}, 16'h0083);
    fl = 8'he2;
    step(2, 4'h5, 1'b1, 16'h0093);
    step(3, 4'h5, 1'b1, 16'h0183);
    fl = 8'he4;
    step(1, 4'h4, 1'b1, 16'h0083);
    $display("test_loads done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    irq_pin = 1'b0;
    fails = 0;
    comparisons = 0;
    ip = 16'h0000;
    fl = 8'he8;
    prog = '{8'h9f, 8'h3d, 8'h40, 8'h5d, 8'h3d, 8'h41, 8'h4d, 8'h6d, 8'h90, 8'h7d,
             8'h9f, 8'hc6, 8'h12, 8'h34, 8'hd6, 8'h01, 8'h23, 8'he6, 8'h7f, 8'ha6,
             8'h55, 8'hb6, 8'h44, 8'hf6, 8'h10, 8'h45, 8'h9d, 8'h48, 8'h00, 8'h50,
             8'hfe, 8'h20, 8'h10, 8'h8f, 8'h9d, 8'h9d, 8'h4d, 8'hae, 8'h83, 8'h5d,
             8'h9f, 8'h6d, 8'h10, 8'hd6, 8'h01, 8'h00, 8'h7d};
    @(posedge mclk);
    for (int i = 0; i < 47; i++) begin
      mem.put(16'(i), prog[i]);
    end
    mem.put(16'h0040, 8'h80);
    mem.put(16'h0041, 8'h01);
    mem.put(16'h0090, 8'h00);
    mem.put(16'h0093, 8'h00);
    repeat (4) @(posedge mclk);
    #1;
    check("reset flags", {8'h00, cond_flags_r}, 16'h00e8);
    check("reset acc", {8'h00, acc_r}, 16'h0000);
    check("reset index", {8'h00, index_r}, 16'h0000);
    check("reset halt", {15'h0000, halt_r}, 16'h0000);
    check("reset addr", mem_addr_r, 16'h0000);
    @(posedge mclk);
    rst <= 1'b0;
    test_zero_flags();
    test_copy();
    test_operand_fetch();
    test_group_map();
    test_branch();
    test_pause();
    test_loads();
    give_verdict();
  end
endmodule
